//--- vdc_config_regs.sv
// Functional notes
// - Route select field is bits 4:0, offset 0x00
// - Route code also sets decode core format
// - Unused analog channels are powered down
// - Composite codes map channels 1-4, 5-6
// - Luma/chroma codes use pairs 1/2,3/4,5/6
// - Component code: luma 1, blue 2, red 3
// - Differential codes use pairs 1/2,3/4,5/6
// - Contrast boost off after reset
// - Writing 0x80 to 0x80 enables boost
// - Writing 0x00 to 0x80 disables boost
// - Progressive converter off after reset
// - Page bits 6:5 select sub-map
// - Strap pin sets slave address bit 1
//
// Register bank of the decoder input routing and feature controls.
// Assumes the serial pins and strap come straight from the package.
`timescale 1ns/1ps
module vdc_config_regs (
   input  wire logic               clk,
   input  wire logic               reset_n,
   input  wire logic               scl_in,
   input  wire logic               sda_in,
   output logic                    sda_out,
   output logic                    sda_oe,
   input  wire logic               address_strap_pin,
   output vdc_pkg::vdc_mode_t      decode_mode,
   output logic [5:0]              chan_power_en,
   output logic [2:0]              chan_primary,
   output logic [2:0]              chan_secondary,
   output logic [2:0]              chan_tertiary,
   output logic [1:0]              submap_page_select,
   output logic                    adaptive_contrast_boost_en,
   output logic                    progressive_converter_en
);
   import vdc_pkg::*;

   logic [7:0]  check_addr, reg_addr, rd_data, wr_addr, wr_data;
   logic        check_ok, wr_stb;
   logic [7:0]  route_reg, route_next;
   logic [7:0]  page_reg, page_next;
   logic [7:0]  contrast_reg, contrast_next;
   logic [7:0]  conv_reg, conv_next;
   vdc_mode_t   mode_reg, mode_next;
   logic [5:0]  power_reg, power_next;
   logic [2:0]  pri_reg, pri_next;
   logic [2:0]  sec_reg, sec_next;
   logic [2:0]  ter_reg, ter_next;
   logic [1:0]  page;

   vdc_serial_target u_port (
      .clk               (clk),
      .reset_n           (reset_n),
      .scl_in            (scl_in),
      .sda_in            (sda_in),
      .sda_out           (sda_out),
      .sda_oe            (sda_oe),
      .address_strap_pin (address_strap_pin),
      .check_addr        (check_addr),
      .check_ok          (check_ok),
      .reg_addr          (reg_addr),
      .rd_data           (rd_data),
      .wr_stb            (wr_stb),
      .wr_addr           (wr_addr),
      .wr_data           (wr_data)
   );

   assign page = page_reg[PAGE_MSB:PAGE_LSB];

   // Which sub-addresses exist in the selected sub-map
   function automatic logic addr_ok(input logic [1:0] pg, input logic [7:0] a);
      addr_ok = (a == SUB_PAGE) ||
                (pg == PAGE_USER && (a == SUB_ROUTE || a == SUB_CONV)) ||
                (pg == PAGE_USER2 && a == SUB_CONTRAST);
   endfunction

   assign check_ok = addr_ok(page, check_addr);

   // Read mux; the page register is visible from every sub-map
   always_comb begin
      rd_data = 8'h00;
      if (reg_addr == SUB_PAGE) rd_data = page_reg;
      else if (page == PAGE_USER && reg_addr == SUB_ROUTE) rd_data = route_reg;
      else if (page == PAGE_USER && reg_addr == SUB_CONV) rd_data = conv_reg;
      else if (page == PAGE_USER2 && reg_addr == SUB_CONTRAST) rd_data = contrast_reg;
   end

   // Register writes, steered by the page select
   always_comb begin
      route_next    = route_reg;
      page_next     = page_reg;
      contrast_next = contrast_reg;
      conv_next     = conv_reg;
      if (wr_stb) begin
         if (wr_addr == SUB_PAGE) page_next = wr_data;
         if (page == PAGE_USER && wr_addr == SUB_ROUTE) route_next = wr_data;
         if (page == PAGE_USER && wr_addr == SUB_CONV) conv_next = wr_data;
         // Only bit 7 matters: 0x80 turns boost on, 0x00 off
         if (page == PAGE_USER2 && wr_addr == SUB_CONTRAST)
            contrast_next = wr_data;
      end
   end

   // Route decode; reserved codes power everything down as a safe fallback
   always_comb begin
      mode_next  = MODE_OFF;
      power_next = 6'h00;
      pri_next   = 3'h0;
      sec_next   = 3'h0;
      ter_next   = 3'h0;
      case (route_reg[ROUTE_MSB:0])
         5'h00, 5'h01, 5'h02, 5'h03: begin
            mode_next  = MODE_CVBS;
            pri_next   = {1'b0, route_reg[1:0]} + 3'h1;
            power_next = 6'h01 << route_reg[1:0];
         end
         5'h06, 5'h07: begin
            mode_next  = MODE_CVBS;
            pri_next   = {2'h2, route_reg[0]} + 3'h1;
            power_next = 6'h10 << route_reg[0];
         end
         5'h08, 5'h09, 5'h0b: begin
            // Code 0b skips a slot, so bit 1 alone picks the third pair
            mode_next  = MODE_YC;
            pri_next   = {route_reg[1] ? 2'h2 : {1'b0, route_reg[0]}, 1'b0} + 3'h1;
            sec_next   = {route_reg[1] ? 2'h2 : {1'b0, route_reg[0]}, 1'b0} + 3'h2;
            power_next = route_reg[1] ? 6'h30 : (6'h03 << {route_reg[0], 1'b0});
         end
         5'h0c: begin
            mode_next  = MODE_COMP;
            pri_next   = 3'h1;
            sec_next   = 3'h2;
            ter_next   = 3'h3;
            power_next = 6'h07;
         end
         5'h0e, 5'h0f, 5'h11: begin
            mode_next  = MODE_DIFF;
            pri_next   = {route_reg[4] ? 2'h2 : {1'b0, route_reg[0]}, 1'b0} + 3'h1;
            sec_next   = {route_reg[4] ? 2'h2 : {1'b0, route_reg[0]}, 1'b0} + 3'h2;
            power_next = route_reg[4] ? 6'h30 : (6'h03 << {route_reg[0], 1'b0});
         end
         default: mode_next = MODE_OFF;
      endcase
   end

   // All state registers; reset leaves boost and converter off
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         route_reg    <= ROUTE_RST;
         page_reg     <= PAGE_RST;
         contrast_reg <= CONTRAST_RST;
         conv_reg     <= CONV_RST;
         mode_reg     <= MODE_OFF;
         power_reg    <= 6'h00;
         pri_reg      <= 3'h0;
         sec_reg      <= 3'h0;
         ter_reg      <= 3'h0;
      end else begin
         route_reg    <= route_next;
         page_reg     <= page_next;
         contrast_reg <= contrast_next;
         conv_reg     <= conv_next;
         mode_reg     <= mode_next;
         power_reg    <= power_next;
         pri_reg      <= pri_next;
         sec_reg      <= sec_next;
         ter_reg      <= ter_next;
      end
   end

   assign decode_mode    = mode_reg;
   assign chan_power_en  = power_reg;
   assign chan_primary   = pri_reg;
   assign chan_secondary = sec_reg;
   assign chan_tertiary  = ter_reg;
   assign submap_page_select         = page;
   assign adaptive_contrast_boost_en = contrast_reg[CONTRAST_BIT];
   assign progressive_converter_en   = conv_reg[CONV_BIT];

   a_field_store: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && page == PAGE_USER && wr_addr == SUB_ROUTE)
      |=> route_reg[4:0] == $past(wr_data[4:0]))
      else $error("route field not stored");
   a_mode_cvbs: assert property (@(posedge clk) disable iff (!reset_n)
      (route_reg[4:0] == 5'h07) |=> decode_mode == MODE_CVBS)
      else $error("composite mode not selected");
   a_power_single: assert property (@(posedge clk) disable iff (!reset_n)
      (decode_mode == MODE_CVBS) |-> $onehot(chan_power_en))
      else $error("extra channels powered");
   a_cvbs_route: assert property (@(posedge clk) disable iff (!reset_n)
      (route_reg[4:0] == 5'h02) ##1 (route_reg[4:0] == 5'h02)
      |-> chan_primary == 3'h3 && chan_power_en == 6'h04)
      else $error("composite channel 3 wrong");
   a_yc_route: assert property (@(posedge clk) disable iff (!reset_n)
      (route_reg[4:0] == 5'h0b) |=>
      decode_mode == MODE_YC && chan_primary == 3'h5 && chan_secondary == 3'h6)
      else $error("luma chroma pair wrong");
   a_comp_route: assert property (@(posedge clk) disable iff (!reset_n)
      (route_reg[4:0] == 5'h0c) |=> chan_power_en == 6'h07 && chan_tertiary == 3'h3)
      else $error("component routing wrong");
   a_diff_route: assert property (@(posedge clk) disable iff (!reset_n)
      (route_reg[4:0] == 5'h0f) |=>
      decode_mode == MODE_DIFF && chan_primary == 3'h3 && chan_power_en == 6'h0c)
      else $error("differential pair wrong");
   a_boost_reset: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(reset_n) |-> !adaptive_contrast_boost_en)
      else $error("boost on after reset");
   a_boost_on: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && page == PAGE_USER2 && wr_addr == SUB_CONTRAST && wr_data == 8'h80)
      |=> adaptive_contrast_boost_en [*2])
      else $error("boost not enabled");
   a_boost_off: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && page == PAGE_USER2 && wr_addr == SUB_CONTRAST && wr_data == 8'h00)
      |=> !adaptive_contrast_boost_en)
      else $error("boost not disabled");
   a_conv_reset: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(reset_n) |-> !progressive_converter_en)
      else $error("converter on after reset");
   a_page_write: assert property (@(posedge clk) disable iff (!reset_n)
      (wr_stb && wr_addr == SUB_PAGE) |=> submap_page_select == $past(wr_data[6:5]))
      else $error("page select not taken");
endmodule

//--- vdc_pkg.sv
// Constants of the video decoder configuration block.
// Assumes one clock domain; serial port pins arrive unsynchronised.
package vdc_pkg;
   // Sub-addresses: route and converter in the main map, contrast in sub-map 2
   localparam logic [7:0] SUB_ROUTE    = 8'h00;
   localparam logic [7:0] SUB_CONV     = 8'h01;
   localparam logic [7:0] SUB_PAGE     = 8'h0e;
   localparam logic [7:0] SUB_CONTRAST = 8'h80;
   localparam logic [7:0] SUB_TOP      = 8'hff;
   // Page select field in the page register
   localparam int         PAGE_LSB     = 5;
   localparam int         PAGE_MSB     = 6;
   localparam logic [1:0] PAGE_USER    = 2'h0;
   localparam logic [1:0] PAGE_INTR    = 2'h1;
   localparam logic [1:0] PAGE_USER2   = 2'h2;
   // Field positions
   localparam int         ROUTE_MSB    = 4;
   localparam int         CONTRAST_BIT = 7;
   localparam int         CONV_BIT     = 0;
   // Reset values
   localparam logic [7:0] ROUTE_RST    = 8'h00;
   localparam logic [7:0] PAGE_RST     = 8'h00;
   localparam logic [7:0] CONTRAST_RST = 8'h00;
   localparam logic [7:0] CONV_RST     = 8'h00;
   // Write address 0x40 as a 7-bit address; bit 0 follows the strap
   localparam logic [6:0] SLAVE_BASE   = 7'h20;
   localparam int         CHAN_N       = 6;
   // Video formats handed to the decode core
   typedef enum logic [2:0] {
      MODE_OFF, MODE_CVBS, MODE_DIFF, MODE_YC, MODE_COMP
   } vdc_mode_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_SUB, ST_WR, ST_RD
   } vdc_state_t;
endpackage

//--- vdc_serial_target.sv
// Serial control port target: byte framing, address match, acknowledge.
// Assumes a slow serial clock, well below a quarter of clk.
`timescale 1ns/1ps
module vdc_serial_target (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   input  wire logic         address_strap_pin,
   output logic [7:0]        check_addr,
   input  wire logic         check_ok,
   output logic [7:0]        reg_addr,
   input  wire logic [7:0]   rd_data,
   output logic              wr_stb,
   output logic [7:0]        wr_addr,
   output logic [7:0]        wr_data
);
   import vdc_pkg::*;

   logic [2:0]  scl_s;
   logic [2:0]  sda_s;
   logic [1:0]  strap_s;
   vdc_state_t  state_reg, state_next;
   logic [3:0]  cnt_reg, cnt_next;
   logic [7:0]  shift_reg, shift_next;
   logic [7:0]  tx_reg, tx_next;
   logic [7:0]  addr_reg, addr_next;
   logic        ack_reg, ack_next;
   logic        drive_reg, drive_next;
   logic        stb_next;
   logic [7:0]  wa_next, wd_next;
   logic        scl_rise, scl_fall, start_c, stop_c;
   logic [6:0]  my_addr;

   // Pins pass two flops; the third stage only feeds edge detection
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         scl_s   <= 3'h7;
         sda_s   <= 3'h7;
         strap_s <= 2'h0;
      end else begin
         scl_s   <= {scl_s[1:0], scl_in};
         sda_s   <= {sda_s[1:0], sda_in};
         strap_s <= {strap_s[0], address_strap_pin};
      end
   end

   assign scl_rise = scl_s[1] & ~scl_s[2];
   assign scl_fall = ~scl_s[1] & scl_s[2];
   assign start_c  = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   assign stop_c   = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];
   assign my_addr  = {SLAVE_BASE[6:1], strap_s[1]};
   assign check_addr = (state_reg == ST_SUB) ? shift_reg : addr_reg;
   assign reg_addr = addr_reg;
   assign sda_out  = 1'b0;   // Open drain: only ever pulls low
   assign sda_oe   = drive_reg;

   // Bit and byte sequencing; start anywhere restarts at the address byte, stop anywhere drops to idle
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      tx_next    = tx_reg;
      addr_next  = addr_reg;
      ack_next   = ack_reg;
      drive_next = drive_reg;
      stb_next   = 1'b0;
      wa_next    = wr_addr;
      wd_next    = wr_data;
      if (start_c) begin
         state_next = ST_ADDR;
         cnt_next   = 4'h0;
         ack_next   = 1'b0;
         drive_next = 1'b0;
      end else if (stop_c) begin
         state_next = ST_IDLE;
         ack_next   = 1'b0;
         drive_next = 1'b0;
      end else if (state_reg != ST_IDLE && scl_rise) begin
         if (ack_reg) begin
            // Master not-acknowledge ends a read
            if (state_reg == ST_RD && sda_s[1]) begin
               state_next = ST_IDLE;
               ack_next   = 1'b0;
            end
         end else begin
            shift_next = {shift_reg[6:0], sda_s[1]};
            cnt_next   = cnt_reg + 4'h1;
         end
      end else if (state_reg != ST_IDLE && scl_fall) begin
         if (ack_reg) begin
            ack_next   = 1'b0;
            cnt_next   = 4'h0;
            drive_next = 1'b0;
            if (state_reg == ST_RD) begin
               tx_next    = {rd_data[6:0], 1'b0};
               drive_next = ~rd_data[7];
               // Past the top the last register repeats
               if (addr_reg != SUB_TOP) addr_next = addr_reg + 8'h01;
            end
         end else if (cnt_reg == 4'h8) begin
            case (state_reg)
               ST_ADDR: begin
                  if (shift_reg[7:1] == my_addr) begin
                     ack_next   = 1'b1;
                     drive_next = 1'b1;
                     state_next = shift_reg[0] ? ST_RD : ST_SUB;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
               ST_SUB: begin
                  // Invalid sub-address gets no acknowledge
                  if (check_ok) begin
                     addr_next  = shift_reg;
                     ack_next   = 1'b1;
                     drive_next = 1'b1;
                     state_next = ST_WR;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
               ST_WR: begin
                  if (check_ok) begin
                     stb_next   = 1'b1;
                     wa_next    = addr_reg;
                     wd_next    = shift_reg;
                     addr_next  = addr_reg + 8'h01;
                     ack_next   = 1'b1;
                     drive_next = 1'b1;
                  end else begin
                     state_next = ST_IDLE;
                  end
               end
               ST_RD: begin
                  ack_next   = 1'b1;
                  drive_next = 1'b0;
               end
               default: state_next = ST_IDLE;
            endcase
         end else if (state_reg == ST_RD) begin
            drive_next = ~tx_reg[7];
            tx_next    = {tx_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg    <= 8'h00;
         addr_reg  <= 8'h00;
         ack_reg   <= 1'b0;
         drive_reg <= 1'b0;
         wr_stb    <= 1'b0;
         wr_addr   <= 8'h00;
         wr_data   <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         tx_reg    <= tx_next;
         addr_reg  <= addr_next;
         ack_reg   <= ack_next;
         drive_reg <= drive_next;
         wr_stb    <= stb_next;
         wr_addr   <= wa_next;
         wr_data   <= wd_next;
      end
   end
endmodule

//--- vdc_host_model.sv
// Host controller model: drives the serial control port of the decoder.
// Assumes the bench resolves the pulled-up data line from both pull-downs.
`timescale 1ns/1ps
module vdc_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   input  wire logic strap,
   output logic      scl,
   output logic      sda_pull
);
   import vdc_pkg::*;
   localparam int QTR = 4;  // Quarter bit in clk cycles; slow enough for the 2-flop sync

   // Bus idles with both lines released
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   // Write address follows the strap level on bit 1
   function automatic logic [7:0] dev_wr_addr();
      return {SLAVE_BASE[6:1], strap, 1'b0};
   endfunction

   task automatic wait_q();
      repeat (QTR) @(posedge clk);
   endtask

   // Start or repeated start: data falls while the clock is high
   task automatic start_cond();
      sda_pull <= 1'b0;
      wait_q();
      scl <= 1'b1;
      wait_q();
      sda_pull <= 1'b1;
      wait_q();
      scl <= 1'b0;
      wait_q();
   endtask

   task automatic stop_cond();
      sda_pull <= 1'b1;
      wait_q();
      scl <= 1'b1;
      wait_q();
      sda_pull <= 1'b0;
      wait_q();
   endtask

   // One bit: data set while the clock is low, line sampled mid-way through high
   task automatic bit_slot(input logic drv, output logic seen);
      sda_pull <= ~drv;
      wait_q();
      scl <= 1'b1;
      wait_q();
      seen = sda_line;
      wait_q();
      scl <= 1'b0;
      wait_q();
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(b[i], seen);
      end
      bit_slot(1'b1, seen);
      ack = ~seen;
   endtask

   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_slot(1'b1, b[i]);
      end
      bit_slot(last, seen);  // Releasing on the last byte ends the read
   endtask

   // Stops at the first refusal, since the target has gone idle by then
   task automatic write_bytes(input logic [7:0] dev, input logic [7:0] sub,
                              input logic [7:0] dat, output logic [2:0] acks);
      acks = 3'h0;
      start_cond();
      send_byte(dev, acks[2]);
      if (acks[2]) send_byte(sub, acks[1]);
      if (acks[1]) send_byte(dat, acks[0]);
      stop_cond();
   endtask

   task automatic write_reg(input logic [7:0] sub, input logic [7:0] dat, output logic ok);
      logic [2:0] acks;
      write_bytes(dev_wr_addr(), sub, dat, acks);
      ok = &acks;
   endtask

   task automatic read_reg(input logic [7:0] sub, output logic [7:0] dat, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start_cond();
      send_byte(dev_wr_addr(), a0);
      send_byte(sub, a1);
      start_cond();
      send_byte(dev_wr_addr() | 8'h01, a2);
      recv_byte(1'b1, dat);
      stop_cond();
      ok = a0 & a1 & a2;
   endtask

   // Three-step boost sequence, always leaving the user page selected
   task automatic set_boost(input logic on, output logic ok);
      logic o1;
      logic o2;
      logic o3;
      write_reg(SUB_PAGE, 8'h40, o1);
      write_reg(SUB_CONTRAST, on ? 8'h80 : 8'h00, o2);
      write_reg(SUB_PAGE, 8'h00, o3);
      ok = o1 & o2 & o3;
   endtask
endmodule

//--- tb.sv
// Self-checking bench for the decoder configuration register bank.
// Assumes the host model owns the serial pins; the data line is pulled up.
`timescale 1ns/1ps
module tb;
   import vdc_pkg::*;
   logic        clk;
   logic        reset_n;
   logic        strap;
   logic        scl;
   logic        sda_pull;
   logic        sda_out;
   logic        sda_oe;
   logic        sda_line;
   vdc_mode_t   decode_mode;
   logic [5:0]  chan_power_en;
   logic [2:0]  chan_p;
   logic [2:0]  chan_s;
   logic [2:0]  chan_t;
   logic [1:0]  page;
   logic        boost_en;
   logic        conv_en;
   logic [17:0] route_vec;
   logic        ok;
   logic [7:0]  rd;
   logic [7:0]  val;
   logic [31:0] rnd;
   logic [2:0]  acks;
   logic [4:0]  code;
   int          error_cnt;
   int          tests_run;
   int          seed;
   // Legal route codes only; reserved codes are never programmed
   logic [4:0]  codes [0:12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h08,
                                 5'h09, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h11};

   always #20 clk = ~clk;

   // Open-drain data line: any pull-down wins over the pull-up
   assign sda_line  = (sda_pull | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1;
   assign route_vec = {decode_mode, chan_power_en, chan_p, chan_s, chan_t};

   vdc_config_regs vdc_config_regs_inst (
      .clk                        (clk),
      .reset_n                    (reset_n),
      .scl_in                     (scl),
      .sda_in                     (sda_line),
      .sda_out                    (sda_out),
      .sda_oe                     (sda_oe),
      .address_strap_pin          (strap),
      .decode_mode                (decode_mode),
      .chan_power_en              (chan_power_en),
      .chan_primary               (chan_p),
      .chan_secondary             (chan_s),
      .chan_tertiary              (chan_t),
      .submap_page_select         (page),
      .adaptive_contrast_boost_en (boost_en),
      .progressive_converter_en   (conv_en)
   );

   vdc_host_model vdc_host_model_inst (
      .clk      (clk),
      .sda_line (sda_line),
      .strap    (strap),
      .scl      (scl),
      .sda_pull (sda_pull)
   );

   // Two-channel formats: pair starting at channel a
   function automatic logic [17:0] pair(input vdc_mode_t m, input logic [2:0] a);
      return {m, 6'h03 << (a - 3'h1), a, a + 3'h1, 3'h0};
   endfunction

   // Expected mode, powered channels and channel routing for a route code
   function automatic logic [17:0] exp_route(input logic [4:0] c);
      case (c)
         5'h00, 5'h01, 5'h02, 5'h03: return {MODE_CVBS, 6'h01 << c[1:0], c[2:0] + 3'h1, 6'h00};
         5'h06, 5'h07: return {MODE_CVBS, 6'h10 << c[0], 3'h5 + {2'h0, c[0]}, 6'h00};
         5'h08: return pair(MODE_YC, 3'h1);
         5'h09: return pair(MODE_YC, 3'h3);
         5'h0b: return pair(MODE_YC, 3'h5);
         5'h0c: return {MODE_COMP, 6'h07, 3'h1, 3'h2, 3'h3};
         5'h0e: return pair(MODE_DIFF, 3'h1);
         5'h0f: return pair(MODE_DIFF, 3'h3);
         5'h11: return pair(MODE_DIFF, 3'h5);
         default: return {MODE_OFF, 6'h00, 9'h000};
      endcase
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Reset for n edges, then leave room for the pin synchronisers
   task automatic do_reset(input int n);
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   task automatic check_reset_state();
      check("boost", boost_en, 1'b0);
      check("converter", conv_en, 1'b0);
      check("page", page, PAGE_USER);
      check("route", route_vec, exp_route(5'h00));
   endtask

   // Hang guard, sized well above the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      error_cnt++;
      $display("[FAIL] run time expected finish seen timeout");
      print_verdict();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      strap = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      seed = 95666;
      do_reset(16);
      check_reset_state();
      $display("test reset state done");
      // Each legal code once, then random codes with random unused upper bits
      for (int i = 0; i < 21; i++) begin
         rnd = $random(seed);
         code = (i < 13) ? codes[i] : codes[rnd[31:8] % 13];
         val = {rnd[7:5], code};
         vdc_host_model_inst.write_reg(SUB_ROUTE, val, ok);
         check("route ack", ok, 1'b1);
         check("route", route_vec, exp_route(code));
         check("route format", route_vec, exp_route(code));
         vdc_host_model_inst.read_reg(SUB_ROUTE, rd, ok);
         check("route read", {ok, rd}, {1'b1, val});
      end
      $display("test route codes done");
      // Page walk: contrast reachable only on page 2, route only on page 0
      vdc_host_model_inst.write_reg(SUB_PAGE, 8'h40, ok);
      check("page 2", page, PAGE_USER2);
      vdc_host_model_inst.write_reg(SUB_CONTRAST, 8'h80, ok);
      vdc_host_model_inst.read_reg(SUB_CONTRAST, rd, ok);
      check("contrast read", {ok, rd, boost_en}, {1'b1, 8'h80, 1'b1});
      vdc_host_model_inst.write_reg(SUB_PAGE, 8'h20, ok);
      check("page 1", page, PAGE_INTR);
      vdc_host_model_inst.write_bytes(8'h40, SUB_ROUTE, 8'h01, acks);
      check("route on page 1", {acks, route_vec}, {3'b100, exp_route(code)});
      vdc_host_model_inst.write_reg(SUB_PAGE, 8'h00, ok);
      check("page 0", page, PAGE_USER);
      vdc_host_model_inst.write_bytes(8'h40, SUB_CONTRAST, 8'h00, acks);
      check("contrast on page 0", {acks, boost_en}, {3'b100, 1'b1});
      $display("test page select done");
      vdc_host_model_inst.set_boost(1'b0, ok);
      check("boost off", {ok, boost_en, page}, {1'b1, 1'b0, PAGE_USER});
      vdc_host_model_inst.set_boost(1'b1, ok);
      check("boost on", {ok, boost_en, page}, {1'b1, 1'b1, PAGE_USER});
      vdc_host_model_inst.write_reg(SUB_CONV, 8'h01, ok);
      check("converter on", {ok, conv_en}, 2'b11);
      $display("test features done");
      // Strap high moves the write address from 0x40 to 0x42
      strap <= 1'b1;
      repeat (4) @(posedge clk);
      vdc_host_model_inst.write_bytes(8'h40, SUB_ROUTE, 8'h01, acks);
      check("old address", acks, 3'b000);
      vdc_host_model_inst.write_reg(SUB_ROUTE, 8'h0f, ok);
      check("new address", {ok, route_vec}, {1'b1, exp_route(5'h0f)});
      $display("test strap done");
      do_reset(2);
      check_reset_state();
      $display("test second reset done");
      print_verdict();
   end
endmodule
